/* File: isd_pkg.sv */
package isd_pkg;

  // Slave address layout: fixed top bits plus strap offsets
  localparam logic [4:0] ADDR_HI_BASE  = 5'h12;  // Binary 10010, high strap at supply
  localparam logic [7:0] ADDR_BYTE_MIN = 8'h90;  // Lowest address byte reachable
  localparam logic [7:0] ADDR_BYTE_MAX = 8'hAE;  // Highest address byte reachable
  localparam int         ADDR_RW_BIT   = 0;      // Direction bit of the address byte
  localparam logic       DIR_WRITE     = 1'h0;   // Direction code for a write cycle
  localparam logic       DIR_READ      = 1'h1;   // Direction code for a read cycle

  // Subaddress byte fields
  localparam int SUB_SPI_RW_BIT = 7;  // Direction bit, SPI host only
  localparam int SUB_REG_MSB    = 6;  // Register index top
  localparam int SUB_REG_LSB    = 3;  // Register index bottom
  localparam int SUB_CH_MSB     = 2;  // Channel field top
  localparam int SUB_CH_LSB     = 1;  // Channel field bottom

  // Channel codes
  localparam logic [1:0] CH_FIRST  = 2'h0;  // First channel
  localparam logic [1:0] CH_SECOND = 2'h1;  // Second channel

  // Values after reset and fixed answers
  localparam logic [7:0] REG_RESET    = 8'h00;  // Register contents after reset
  localparam logic [7:0] RSV_READ     = 8'hFF;  // Answer for a reserved channel
  localparam logic [3:0] BIT_CNT_RST  = 4'h0;   // Bit counter after reset
  localparam logic [3:0] BIT_CNT_FULL = 4'h8;   // Bits in one byte
  localparam logic [1:0] STRAP_SETTLE = 2'h3;   // Cycles before straps are caught

  // Four ways a strap pin can be tied
  typedef enum logic [1:0] {
    STRAP_SUPPLY,
    STRAP_GROUND,
    STRAP_CLOCK,
    STRAP_DATA
  } isd_strap_e;

  // Bus-side protocol states
  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_SUB,
    ST_SUB_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RACK
  } isd_state_e;

  // Seven-bit slave address from the two strap codes
  function automatic logic [6:0] isd_dev_addr(input logic [1:0] hi, input logic [1:0] lo);
    isd_dev_addr = {5'(ADDR_HI_BASE + {3'h0, hi}), lo};
  endfunction

  // Only the first two channel codes name real registers
  function automatic logic isd_ch_valid(input logic [1:0] ch);
    isd_ch_valid = (ch == CH_FIRST) || (ch == CH_SECOND);
  endfunction

  // Direction carried in the subaddress when it arrives over SPI
  function automatic logic isd_spi_sub_read(input logic [7:0] sub);
    isd_spi_sub_read = sub[SUB_SPI_RW_BIT];  // [R14]
  endfunction

endpackage

/* File: isd_mem_if.sv */
`timescale 1ns/100ps
interface isd_mem_if;
  logic       we;     // One-cycle write strobe
  logic [1:0] ch;     // Channel of the access
  logic [3:0] idx;    // Register index in the channel
  logic [7:0] wdata;  // Byte to store
  logic [7:0] rdata;  // Registered read answer

  modport master (output we, output ch, output idx, output wdata, input rdata);
  modport mem    (input we, input ch, input idx, input wdata, output rdata);
endinterface

/* File: isd_regmem.sv */
`timescale 1ns/100ps
module isd_regmem #(
  parameter int CHANNELS = 2,
  parameter int REGS     = 16
) (
  input wire logic clk,
  input wire logic rstn,
  isd_mem_if.mem   port
);

  logic [7:0] store [CHANNELS][REGS];  // Register contents per channel

  ////////////////////////////////////////////////////////////////////////////
  // Write port; a reserved channel never lands in the array
  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int c = 0; c < CHANNELS; c++) begin
        for (int r = 0; r < REGS; r++) begin
          store[c][r] <= isd_pkg::REG_RESET;
        end
      end
    end else if (port.we && isd_pkg::isd_ch_valid(port.ch)) begin  // [R16]
      store[port.ch[0]][port.idx] <= port.wdata;  // [R7]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered read; reserved channel answers a fixed byte
  always_ff @(posedge clk) begin
    if (!rstn) begin
      port.rdata <= isd_pkg::REG_RESET;
    end else if (!isd_pkg::isd_ch_valid(port.ch)) begin
      port.rdata <= isd_pkg::RSV_READ;  // [R16]
    end else begin
      port.rdata <= store[port.ch[0]][port.idx];
    end
  end

  wr_reserved_a: assert property (@(posedge clk) disable iff (!rstn)
    port.we && !isd_pkg::isd_ch_valid(port.ch) |=> $stable(store[0][port.idx]) && $stable(store[1][port.idx]))
    else $error("Reserved channel write changed a register");

endmodule

/* File: isd_i2c_slave.sv */
`timescale 1ns/100ps
// Summary of operation
// (R1) Slave address comes from two strap pins
// (R2) Straps map address bytes 0x90 through 0xAE
// (R3) Address bit 0: 0 write, 1 read
// (R4) Master sends subaddress right after address
// (R5) Subaddress is a full byte, acknowledged
// (R6) Write: START, address, subaddress, data, STOP
// (R7) Written bytes go to the selected register
// (R8) Read: subaddress, repeated START, read address
// (R9) Device shifts bytes out, expects master ack
// (R10) Master nacks last byte, then sends STOP
// (R11) Subaddress bits 2:1 pick the channel
// (R12) Subaddress bits 6:3 pick the register
// (R13) Bit 0 ignored; bit 7 ignored here
// (R14) Over SPI bit 7 gives direction
// (R15) Acknowledge only our own address
// (R16) Reserved channel: no write, fixed read
module isd_i2c_slave (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       scl_in,           // Bus clock pin level
  input  wire logic       sda_in,           // Bus data pin level
  output logic            sda_out,          // Data drive level, always low
  output logic            sda_oe,           // High while pulling data low
  input  wire logic [1:0] addr_strap_high,  // Tie code of the high strap pin
  input  wire logic [1:0] addr_strap_low,   // Tie code of the low strap pin
  output logic            addressed,        // High while a cycle is ours
  output logic [1:0]      sel_channel,      // Channel of the current subaddress
  output logic [3:0]      sel_index         // Register of the current subaddress
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [1:0] scl_sync;       // Clock pin synchroniser
  logic [1:0] sda_sync;       // Data pin synchroniser
  logic       scl_prev;       // Clock level one cycle earlier
  logic       sda_prev;       // Data level one cycle earlier
  logic [1:0] hi_sync0;       // High strap first stage
  logic [1:0] hi_sync1;       // High strap second stage
  logic [1:0] lo_sync0;       // Low strap first stage
  logic [1:0] lo_sync1;       // Low strap second stage
  logic [1:0] strap_wait;     // Settling count after reset
  logic       strap_ok;       // Straps have been caught
  logic [6:0] dev_addr;       // Own seven-bit address
  logic       scl_rise;       // Clock rising edge seen
  logic       scl_fall;       // Clock falling edge seen
  logic       bus_start;      // START or repeated START
  logic       bus_stop;       // STOP
  isd_pkg::isd_state_e state; // Protocol state
  logic [3:0] bit_cnt;        // Bits of the current byte
  logic [7:0] shift;          // Byte being shifted
  logic       dir;            // Direction of the current cycle
  logic       master_ack;     // Master acked the last read byte
  logic       byte_done;      // Eighth bit clocked, at falling edge
  logic       addr_match;     // Address byte is ours

  isd_mem_if mem ();

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge clk) begin
    if (!rstn) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
    end
  end

  // Previous synchronised levels for edge finding
  always_ff @(posedge clk) begin
    if (!rstn) begin
      scl_prev <= 1'h1;
      sda_prev <= 1'h1;
    end else begin
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  // Edges and bus conditions; data moving while clock high is control
  assign scl_rise  = scl_sync[1] && !scl_prev;
  assign scl_fall  = !scl_sync[1] && scl_prev;
  assign bus_start = scl_sync[1] && scl_prev && sda_prev && !sda_sync[1];
  assign bus_stop  = scl_sync[1] && scl_prev && !sda_prev && sda_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture: the pad decodes each tie into a code, we catch it once
  always_ff @(posedge clk) begin
    if (!rstn) begin
      hi_sync0 <= 2'h0;
      hi_sync1 <= 2'h0;
      lo_sync0 <= 2'h0;
      lo_sync1 <= 2'h0;
    end else begin
      hi_sync0 <= addr_strap_high;
      hi_sync1 <= hi_sync0;
      lo_sync0 <= addr_strap_low;
      lo_sync1 <= lo_sync0;
    end
  end

  // Latch the address after the synchronisers settle; straps never move later
  always_ff @(posedge clk) begin
    if (!rstn) begin
      strap_wait <= 2'h0;
      strap_ok   <= 1'h0;
      dev_addr   <= 7'h00;
    end else if (!strap_ok) begin
      strap_wait <= 2'(strap_wait + 2'h1);
      if (strap_wait == isd_pkg::STRAP_SETTLE) begin
        strap_ok <= 1'h1;
        dev_addr <= isd_pkg::isd_dev_addr(hi_sync1, lo_sync1);  // [R1] [R2]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte framing helpers
  assign byte_done  = scl_fall && (bit_cnt == isd_pkg::BIT_CNT_FULL);
  assign addr_match = strap_ok && (shift[7:1] == dev_addr);  // [R15]

  // Bit counter and shifter; receive on rising edge, send on falling
  always_ff @(posedge clk) begin
    if (!rstn) begin
      bit_cnt <= isd_pkg::BIT_CNT_RST;
      shift   <= 8'h00;
    end else if (bus_start || byte_done) begin
      bit_cnt <= isd_pkg::BIT_CNT_RST;
      if (byte_done && (state == isd_pkg::ST_RDATA)) begin
        shift <= 8'h00;
      end
    end else if (scl_fall && ((state == isd_pkg::ST_ADDR_ACK && dir == isd_pkg::DIR_READ)
                              || (state == isd_pkg::ST_RACK && master_ack))) begin
      shift <= mem.rdata;  // [R9]
    end else if (scl_rise && state inside {isd_pkg::ST_ADDR, isd_pkg::ST_SUB, isd_pkg::ST_WDATA}) begin
      shift   <= {shift[6:0], sda_sync[1]};  // Most significant bit first
      bit_cnt <= 4'(bit_cnt + 4'h1);
    end else if (state == isd_pkg::ST_RDATA) begin
      if (scl_rise) begin
        bit_cnt <= 4'(bit_cnt + 4'h1);
      end else if (scl_fall) begin
        shift <= {shift[6:0], 1'h0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protocol sequencer; START from anywhere restarts, which covers repeated START
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= isd_pkg::ST_IDLE;
    end else if (bus_stop) begin
      state <= isd_pkg::ST_IDLE;
    end else if (bus_start) begin
      state <= isd_pkg::ST_ADDR;  // [R8]
    end else if (scl_fall) begin
      unique case (state)
        isd_pkg::ST_IDLE: begin
          state <= isd_pkg::ST_IDLE;
        end
        isd_pkg::ST_ADDR: begin
          if (byte_done) begin
            state <= addr_match ? isd_pkg::ST_ADDR_ACK : isd_pkg::ST_IDLE;  // [R15]
          end
        end
        isd_pkg::ST_ADDR_ACK: begin
          state <= (dir == isd_pkg::DIR_READ) ? isd_pkg::ST_RDATA : isd_pkg::ST_SUB;  // [R3] [R4]
        end
        isd_pkg::ST_SUB: begin
          if (byte_done) begin
            state <= isd_pkg::ST_SUB_ACK;  // [R5]
          end
        end
        isd_pkg::ST_SUB_ACK: begin
          state <= isd_pkg::ST_WDATA;  // [R6]
        end
        isd_pkg::ST_WDATA: begin
          if (byte_done) begin
            state <= isd_pkg::ST_WDATA_ACK;
          end
        end
        isd_pkg::ST_WDATA_ACK: begin
          state <= isd_pkg::ST_WDATA;  // Any number of data bytes
        end
        isd_pkg::ST_RDATA: begin
          if (byte_done) begin
            state <= isd_pkg::ST_RACK;
          end
        end
        isd_pkg::ST_RACK: begin
          state <= master_ack ? isd_pkg::ST_RDATA : isd_pkg::ST_IDLE;  // [R10]
        end
      endcase
    end
  end

  // Direction caught from the address byte
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dir <= isd_pkg::DIR_WRITE;
    end else if (state == isd_pkg::ST_ADDR && byte_done) begin
      dir <= shift[isd_pkg::ADDR_RW_BIT];  // [R3]
    end
  end

  // Master acknowledge sampled on the ninth rising edge of a read byte
  always_ff @(posedge clk) begin
    if (!rstn) begin
      master_ack <= 1'h0;
    end else if (state == isd_pkg::ST_RACK && scl_rise) begin
      master_ack <= !sda_sync[1];  // [R9] [R10]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Subaddress decode; bits 7 and 0 take no part on this host port
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sel_channel <= isd_pkg::CH_FIRST;
      sel_index   <= 4'h0;
    end else if (state == isd_pkg::ST_SUB && byte_done) begin
      sel_channel <= shift[isd_pkg::SUB_CH_MSB:isd_pkg::SUB_CH_LSB];   // [R11] [R13]
      sel_index   <= shift[isd_pkg::SUB_REG_MSB:isd_pkg::SUB_REG_LSB]; // [R12]
    end
  end

  // Write strobe after each data byte; every byte hits the same location.
  // Reserved channels still strobe; the memory refuses them itself
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mem.we    <= 1'h0;
      mem.wdata <= isd_pkg::REG_RESET;
    end else begin
      mem.we <= (state == isd_pkg::ST_WDATA) && byte_done;  // [R7]
      if (state == isd_pkg::ST_WDATA && byte_done) begin
        mem.wdata <= shift;
      end
    end
  end

  // Memory address follows the decoded subaddress
  assign mem.ch  = sel_channel;
  assign mem.idx = sel_index;

  isd_regmem #(
    .CHANNELS (2),
    .REGS     (16)
  ) u_regmem (
    .clk  (clk),
    .rstn (rstn),
    .port (mem.mem)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Data pin drive: only a low is ever driven, released otherwise
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sda_oe  <= 1'h0;
      sda_out <= 1'h0;
    end else if (bus_start || bus_stop) begin
      sda_oe <= 1'h0;
    end else if (scl_fall) begin
      unique case (state)
        isd_pkg::ST_ADDR:      sda_oe <= byte_done && addr_match;  // [R15]
        isd_pkg::ST_SUB:       sda_oe <= byte_done;                // [R5]
        isd_pkg::ST_WDATA:     sda_oe <= byte_done;
        isd_pkg::ST_ADDR_ACK:  sda_oe <= (dir == isd_pkg::DIR_READ) && !mem.rdata[7];
        isd_pkg::ST_RDATA:     sda_oe <= !byte_done && !shift[6];  // [R9]
        isd_pkg::ST_RACK:      sda_oe <= master_ack && !mem.rdata[7];
        default:               sda_oe <= 1'h0;
      endcase
    end
  end

  // Cycle ownership flag for the core
  always_ff @(posedge clk) begin
    if (!rstn) begin
      addressed <= 1'h0;
    end else begin
      addressed <= !(state inside {isd_pkg::ST_IDLE, isd_pkg::ST_ADDR});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  strap_range_a: assert property (@(posedge clk) disable iff (!rstn)  // [R2]
    strap_ok |-> {dev_addr, 1'h0} >= isd_pkg::ADDR_BYTE_MIN && {dev_addr, 1'h0} <= isd_pkg::ADDR_BYTE_MAX)
    else $error("Strap address out of range");

  foreign_addr_a: assert property (@(posedge clk) disable iff (!rstn)  // [R15]
    state == isd_pkg::ST_ADDR && byte_done && !addr_match |=> !sda_oe && state == isd_pkg::ST_IDLE)
    else $error("Foreign address was acknowledged");

  own_addr_a: assert property (@(posedge clk) disable iff (!rstn)  // [R1]
    state == isd_pkg::ST_ADDR && byte_done && addr_match && !bus_stop |=> sda_oe && state == isd_pkg::ST_ADDR_ACK)
    else $error("Own address not acknowledged");

  dir_split_a: assert property (@(posedge clk) disable iff (!rstn)  // [R3]
    state == isd_pkg::ST_ADDR_ACK && scl_fall && !bus_start && !bus_stop
    |=> (state == isd_pkg::ST_RDATA) == (dir == isd_pkg::DIR_READ))
    else $error("Direction bit not honoured");

  sub_ack_a: assert property (@(posedge clk) disable iff (!rstn)  // [R5]
    state == isd_pkg::ST_SUB && byte_done && !bus_stop |=> sda_oe ##0 state == isd_pkg::ST_SUB_ACK)
    else $error("Subaddress not acknowledged");

  sub_decode_a: assert property (@(posedge clk) disable iff (!rstn)  // [R11] [R12] [R13]
    state == isd_pkg::ST_SUB && byte_done
    |=> sel_channel == $past(shift[2:1]) && sel_index == $past(shift[6:3]))
    else $error("Subaddress decoded wrongly");

  write_strobe_a: assert property (@(posedge clk) disable iff (!rstn)  // [R7]
    state == isd_pkg::ST_WDATA && byte_done && isd_pkg::isd_ch_valid(sel_channel)
    |=> mem.we && mem.wdata == $past(shift) ##1 !mem.we)
    else $error("Data byte not written once");

  rack_release_a: assert property (@(posedge clk) disable iff (!rstn)  // [R9]
    state == isd_pkg::ST_RACK |-> !sda_oe)
    else $error("Data held during master acknowledge");

  nack_end_a: assert property (@(posedge clk) disable iff (!rstn)  // [R10]
    state == isd_pkg::ST_RACK && scl_fall && !master_ack && !bus_start |=> state == isd_pkg::ST_IDLE)
    else $error("Read went on after a nack");

  write_seen_c: cover property (@(posedge clk) disable iff (!rstn) mem.we);
  read_seen_c: cover property (@(posedge clk) disable iff (!rstn)
    state == isd_pkg::ST_RACK && scl_fall && !master_ack);
  foreign_seen_c: cover property (@(posedge clk) disable iff (!rstn)
    state == isd_pkg::ST_ADDR && byte_done && !addr_match);
  resv_seen_c: cover property (@(posedge clk) disable iff (!rstn)
    state == isd_pkg::ST_WDATA && byte_done && !isd_pkg::isd_ch_valid(sel_channel));

endmodule

/* File: isd_master_model.sv */
`timescale 1ns/100ps
// Bus master model: owns the clock line, drives data open-drain
module isd_master_model (
  input  wire logic clk,       // System clock, paces every bus phase
  input  wire logic sda_line,  // Resolved data wire
  output logic      scl,       // Bus clock, high when idle
  output logic      sda_m      // Master drive, 1 means released
);
  // Idle bus: both lines high through the pull-ups
  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end

  ////////////////////////////////////////////////////////////
  // Wait a number of system clock edges
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // START or repeated START: data falls while the clock is high
  task automatic start();
    sda_m <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(5);
    sda_m <= 1'b0;
    tick(5);
    scl <= 1'b0;
    tick(3);
  endtask

  // One clock pulse: 5 clk low, 5 clk high, data moves only while low
  task automatic bit_xfer(input logic b, output logic r);
    sda_m <= b;
    tick(2);
    scl <= 1'b1;
    tick(4);
    // Sample between edges so the device's register has settled
    @(negedge clk);
    r = sda_line;
    @(posedge clk);
    scl <= 1'b0;
    tick(3);
  endtask

  // STOP: data rises while the clock is high
  task automatic stop();
    sda_m <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(5);
    sda_m <= 1'b1;
    tick(5);
  endtask

  // Byte out, MSB first, then release for the device's acknowledge
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
    bit_xfer(1'b1, r);
    ack = (r === 1'b0);
  endtask

  // Byte in, then acknowledge, or not on the last byte
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
    bit_xfer(last, r);
  endtask
endmodule

/* File: testbench.sv */
`timescale 1ns/100ps
module testbench;
  logic       clk;          // System clock
  logic       rstn;         // Synchronous reset, active low
  logic       scl;          // Bus clock from the master
  logic       sda_m;        // Master data drive
  logic       sda_oe;       // Device pulls data
  logic       sda_out;      // Device drive level
  logic       sda_line;     // Resolved data wire
  logic [1:0] strap_hi;     // High strap tie code
  logic [1:0] strap_lo;     // Low strap tie code
  logic       addressed;    // Cycle is ours
  logic [1:0] sel_channel;  // Decoded channel
  logic [3:0] sel_index;    // Decoded register
  logic [7:0] dev_addr;     // Expected write address byte
  int         bad_count;    // Mismatches
  int         checks;       // Comparisons
  int         cycles = 0;   // Run length guard

  initial clk = 1'b0;
  always #4 clk = ~clk;

  // Open-drain wire with pull-up: low when either side pulls
  assign sda_line = sda_oe ? (sda_out & sda_m) : sda_m;

  isd_i2c_slave i_dut (
    .clk             (clk),
    .rstn            (rstn),
    .scl_in          (scl),
    .sda_in          (sda_line),
    .sda_out         (sda_out),
    .sda_oe          (sda_oe),
    .addr_strap_high (strap_hi),
    .addr_strap_low  (strap_lo),
    .addressed       (addressed),
    .sel_channel     (sel_channel),
    .sel_index       (sel_index)
  );

  isd_master_model i_master (
    .clk      (clk),
    .sda_line (sda_line),
    .scl      (scl),
    .sda_m    (sda_m)
  );

  ////////////////////////////////////////////////////////////
  // Closing report, the only exit
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Hang guard, a few times the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      $display("unexpected at %0t: run did not finish", $time);
      wrap_up();
    end
  end

  // Reset with new straps; straps must be steady before release
  task automatic do_reset(input logic [1:0] hi, input logic [1:0] lo);
    rstn     <= 1'b0;
    strap_hi <= hi;
    strap_lo <= lo;
    repeat (6) @(posedge clk);
    check({sda_oe, addressed, sel_channel, sel_index}, 8'h00, "outputs in reset");
    rstn <= 1'b1;
    repeat (12) @(posedge clk);
    // High strap adds 0..3 to 10010, low strap fills bits 2:1
    dev_addr = {5'h12 + {3'h0, hi}, lo, 1'b0};
  endtask

  ////////////////////////////////////////////////////////////
  // Write cycle with two data bytes to one subaddress
  task automatic wr_reg(input logic [7:0] sub, input logic [7:0] d0, input logic [7:0] d1);
    logic a0, a1, a2, a3;
    i_master.start();
    i_master.send_byte(dev_addr, a0);
    i_master.send_byte(sub, a1);
    i_master.send_byte(d0, a2);
    i_master.send_byte(d1, a3);
    i_master.stop();
    check({4'h0, a0, a1, a2, a3}, 8'h0F, "write acks");
  endtask

  // Read cycle: subaddress, repeated START, two bytes
  task automatic rd_chk(input logic [7:0] sub, input logic [7:0] exp);
    logic       a0, a1, a2;
    logic [7:0] d0, d1;
    i_master.start();
    i_master.send_byte(dev_addr, a0);
    i_master.send_byte(sub, a1);
    i_master.start();
    i_master.send_byte(dev_addr | 8'h01, a2);
    i_master.recv_byte(1'b0, d0);
    i_master.recv_byte(1'b1, d1);
    i_master.stop();
    check({5'h0, a0, a1, a2}, 8'h07, "read acks");
    check(d0, exp, "first read byte");
    check(d1, exp, "second read byte");
    check({7'h0, addressed}, 8'h00, "idle after stop");
  endtask

  // All sixteen strap pairs, a neighbour address ignored
  task automatic t_addr_map();
    logic a0, a1;
    for (int h = 0; h < 4; h++) begin
      for (int l = 0; l < 4; l++) begin
        do_reset(2'(h), 2'(l));
        i_master.start();
        i_master.send_byte(dev_addr ^ 8'h02, a0);
        check({7'h0, addressed}, 8'h00, "foreign address");
        i_master.stop();
        i_master.start();
        i_master.send_byte(dev_addr, a1);
        check({7'h0, addressed}, 8'h01, "own address");
        i_master.stop();
        check({6'h0, a0, a1}, 8'h01, "address acks");
      end
    end
  endtask

  // Decode of the subaddress, ignored bits set, last byte kept
  task automatic t_write_read();
    wr_reg(8'hAB, 8'h3C, 8'hA5);
    check({2'h0, sel_channel, sel_index}, 8'h15, "sub decode");
    rd_chk(8'h2A, 8'hA5);
    wr_reg(8'h28, 8'h00, 8'h11);
    rd_chk(8'h2A, 8'hA5);
    rd_chk(8'h28, 8'h11);
    rd_chk(8'h78, 8'h00);
  endtask

  // Reserved channels: write dropped, fixed read answer
  task automatic t_reserved();
    wr_reg(8'h2C, 8'h77, 8'h77);
    rd_chk(8'h2C, 8'hFF);
    rd_chk(8'h2E, 8'hFF);
    rd_chk(8'h28, 8'h11);
    rd_chk(8'h2A, 8'hA5);
  endtask

  // STOP inside a data byte leaves the register untouched
  task automatic t_abort();
    logic a0, a1, r;
    i_master.start();
    i_master.send_byte(dev_addr, a0);
    i_master.send_byte(8'h28, a1);
    for (int i = 0; i < 4; i++) i_master.bit_xfer(1'b0, r);
    i_master.stop();
    check({6'h0, a0, a1}, 8'h03, "abort acks");
    rd_chk(8'h28, 8'h11);
  endtask

  // Direction bit of the SPI form of the subaddress
  task automatic t_spi_dir();
    check({7'h0, isd_pkg::isd_spi_sub_read(8'h80)}, 8'h01, "spi read");
    check({7'h0, isd_pkg::isd_spi_sub_read(8'h7F)}, 8'h00, "spi write");
  endtask

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rstn     = 1'b0;
    strap_hi = 2'h0;
    strap_lo = 2'h0;
    t_addr_map();
    do_reset(2'h2, 2'h1);
    t_write_read();
    t_reserved();
    t_abort();
    t_spi_dir();
    wrap_up();
  end
endmodule
